// ===== common/pole_pkg.sv
// Constants, field layouts and state codes for the pole detection sequencer
package pole_pkg;

  // Register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register offsets
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFS_TORQUE_OFS = 8'h14;
  localparam logic [7:0] OFS_TRAVEL = 8'h18;

  // Configuration register fields
  localparam int SCHED_LSB = 0;
  localparam int SCHED_W = 3;
  localparam int METHOD_LSB = 4;
  localparam int METHOD_W = 3;
  localparam int LIMIT_BIT = 8;
  localparam int ENC_ABS_BIT = 9;
  localparam int TEST_BIT = 12;
  localparam int RESP_LSB = 16;
  localparam int RESP_W = 4;
  localparam logic [31:0] CFG_RESET = 32'h0000_0001;
  localparam logic [31:0] CFG_MASK = 32'h000F_1377;

  // Setting values
  localparam logic [2:0] SCHED_OFF = 3'h0;
  localparam logic [2:0] SCHED_FIRST = 3'h1;
  localparam logic [2:0] SCHED_EVERY = 3'h5;
  localparam logic [2:0] METHOD_POSITION = 3'h0;
  localparam logic [2:0] METHOD_MINUTE = 3'h4;
  localparam logic LIMIT_ENABLED = 1'b0;

  // Command register bits
  localparam int SOFT_RESET_BIT = 0;
  localparam int FAULT_CLEAR_BIT = 1;

  // Interrupt event bits
  localparam int IRQ_W = 4;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FAULT = 1;
  localparam int IRQ_REVERSE = 2;
  localparam int IRQ_EARLY = 3;

  // Status register fields
  localparam int ST_STATE_LSB = 0;
  localparam int ST_DONE_BIT = 2;
  localparam int ST_READY_BIT = 3;
  localparam int ST_DIR_BIT = 4;
  localparam int ST_TEST_BIT = 5;
  localparam int ST_CAUSE_LSB = 8;

  // Fault causes
  localparam logic [2:0] FC_NONE = 3'h0;
  localparam logic [2:0] FC_LIMITS = 3'h1;
  localparam logic [2:0] FC_DISTURB = 3'h2;
  localparam logic [2:0] FC_TRAVEL = 3'h3;
  localparam logic [2:0] FC_ENGINE = 3'h4;

  // Travel bound of the minute method, in micrometres (0.5 mm)
  localparam int MINUTE_TRAVEL_UM = 500;
  localparam int NM_PER_UM = 1000;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DETECT = 2'b01,
    ST_RUN = 2'b10,
    ST_FAULT = 2'b11
  } seq_state_e;

endpackage : pole_pkg

// ===== hw/pin_sync.sv
// Two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 3
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Pins and synchronised copies
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_sync
);

  genvar i;

  // One pair of flops per pin; the first flop feeds only the second
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic stage1_r;
      logic stage2_r;
      always_ff @(posedge core_clk) begin
        if (reset) begin
          stage1_r <= 1'b0;
          stage2_r <= 1'b0;
        end else begin
          stage1_r <= pin_in[i];
          stage2_r <= stage1_r;
        end
      end
      assign pin_sync[i] = stage2_r;
    end
  endgenerate

endmodule : pin_sync

// ===== hw/travel_meter.sv
// Saturating travel counter with an over-limit flag
`timescale 1ns/1ps
module travel_meter #(
  parameter int W = 16,
  parameter logic [W-1:0] LIMIT = 16'h01F4
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Control and step input
  input wire logic clear,
  input wire logic step,
  // Result
  output logic [W-1:0] count,
  output logic over
);

  logic [W-1:0] count_r;
  logic [W-1:0] count_nxt;
  logic at_max;

  // Counts steps and stops at the top instead of wrapping
  assign at_max = &count_r;
  assign count_nxt = clear ? '0 :
                     (step && !at_max) ? count_r + 1'b1 : count_r;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

  assign count = count_r;
  assign over = (count_r > LIMIT);

endmodule : travel_meter

// ===== hw/pole_detection_sequencer.sv
// Sequencer deciding when and how initial magnetic pole detection runs
//
// Behaviour
// - Schedule setting: 0 off, 1 first, 5 every.
// - Method setting: 0 position, 4 minute method.
// - Limit setting: 0 honours stroke ends, 1 ignores.
// - Pending detection starts moving at servo-on.
// - Torque offset to the current loop is zero while detecting; the register reads back unchanged.
// - Minute method travel beyond 0.5 mm raises detection fault.
// - Minute method disturbance raises detection fault.
// - The stroke end ahead of the motion off reverses; both faults.
// - Incremental encoder detects after every reset.
`timescale 1ns/1ps
module pole_detection_sequencer #(
  parameter int ENC_RES_NM = 1000,
  parameter int TRAVEL_W = 16,
  parameter int OFFSET_W = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Register port
  input wire logic [pole_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pole_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [pole_pkg::DATA_W-1:0] reg_rdata,
  // Motion controller side
  input wire logic servo_on_pin,
  input wire logic pos_cmd,
  output logic ready,
  // Stroke-end pins, high while the axis is inside its stroke
  input wire logic forward_travel_limit,
  input wire logic reverse_travel_limit,
  // Detection engine side
  output logic detect_run,
  output logic detect_dir,
  output logic detect_method_minute,
  output logic [pole_pkg::RESP_W-1:0] minute_method_response,
  input wire logic detect_done,
  input wire logic detect_fail,
  input wire logic detect_disturb,
  input wire logic move_step,
  // Torque offset to the current loop
  output logic [OFFSET_W-1:0] torque_offset_eff,
  // Status outputs
  output logic initial_pole_detect_fault,
  output logic test_run_active,
  output logic irq
);

  localparam int TRAVEL_LIMIT_INT =
    pole_pkg::MINUTE_TRAVEL_UM * pole_pkg::NM_PER_UM / ENC_RES_NM;
  localparam logic [TRAVEL_W-1:0] TRAVEL_LIMIT =
    TRAVEL_W'(TRAVEL_LIMIT_INT);

  // Synchronised pins
  logic [2:0] pins_raw;
  logic [2:0] pins_s;
  logic servo_on_s;
  logic fwd_on;
  logic rev_on;

  // Registers
  logic [pole_pkg::DATA_W-1:0] cfg_r;
  logic [pole_pkg::DATA_W-1:0] cfg_nxt;
  logic [pole_pkg::IRQ_W-1:0] irq_stat_r;
  logic [pole_pkg::IRQ_W-1:0] irq_stat_nxt;
  logic [pole_pkg::IRQ_W-1:0] irq_mask_r;
  logic [OFFSET_W-1:0] torque_ofs_r;
  logic [pole_pkg::DATA_W-1:0] rdata_r;
  logic [pole_pkg::DATA_W-1:0] rdata_nxt;

  // Sequencer state
  pole_pkg::seq_state_e state_r;
  pole_pkg::seq_state_e state_nxt;
  logic done_r;
  logic done_nxt;
  logic dir_r;
  logic dir_nxt;
  logic servo_q_r;
  logic test_active_r;
  logic [2:0] cause_r;
  logic [2:0] cause_nxt;

  // Decoded settings and events
  logic [2:0] sched;
  logic [2:0] method;
  logic minute;
  logic limits_used;
  logic enc_abs;
  logic servo_rise;
  logic detect_needed;
  logic wr_cfg;
  logic wr_cmd;
  logic wr_irq_stat;
  logic wr_irq_mask;
  logic wr_torque;
  logic soft_reset;
  logic fault_clear;
  logic both_off;
  logic rev_needed;
  logic fault_hit;
  logic [2:0] fault_cause;
  logic finished;
  logic [pole_pkg::IRQ_W-1:0] events;
  logic [TRAVEL_W-1:0] travel_count;
  logic travel_over;
  logic meter_clear;

  // Address decode shared by every write
  function automatic logic hit(input logic [pole_pkg::ADDR_W-1:0] a,
                               input logic [pole_pkg::ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // Servo-on and stroke-end pins cross into the core clock
  assign pins_raw = {servo_on_pin, forward_travel_limit,
                     reverse_travel_limit};

  pin_sync #(
    .W(3)
  ) u_pin_sync (
    .core_clk(core_clk),
    .reset(reset),
    .pin_in(pins_raw),
    .pin_sync(pins_s)
  );

  assign servo_on_s = pins_s[2];
  assign fwd_on = pins_s[1];
  assign rev_on = pins_s[0];

  // Write strobes per register
  assign wr_cfg = reg_wr && hit(reg_addr, pole_pkg::OFS_CFG);
  assign wr_cmd = reg_wr && hit(reg_addr, pole_pkg::OFS_CMD);
  assign wr_irq_stat = reg_wr && hit(reg_addr, pole_pkg::OFS_IRQ_STAT);
  assign wr_irq_mask = reg_wr && hit(reg_addr, pole_pkg::OFS_IRQ_MASK);
  assign wr_torque = reg_wr && hit(reg_addr, pole_pkg::OFS_TORQUE_OFS);
  assign soft_reset = wr_cmd && reg_wdata[pole_pkg::SOFT_RESET_BIT];
  assign fault_clear = wr_cmd && reg_wdata[pole_pkg::FAULT_CLEAR_BIT];

  // Setting fields
  assign sched = cfg_r[pole_pkg::SCHED_LSB +: pole_pkg::SCHED_W];
  assign method = cfg_r[pole_pkg::METHOD_LSB +: pole_pkg::METHOD_W];
  assign minute = (method == pole_pkg::METHOD_MINUTE);
  assign limits_used =
    (cfg_r[pole_pkg::LIMIT_BIT] == pole_pkg::LIMIT_ENABLED);
  assign enc_abs = cfg_r[pole_pkg::ENC_ABS_BIT];
  assign cfg_nxt = reg_wdata & pole_pkg::CFG_MASK;

  // Whether the coming servo-on must run detection
  assign detect_needed =
    !enc_abs ? !done_r :
    (sched == pole_pkg::SCHED_EVERY) ? 1'b1 :
    (sched == pole_pkg::SCHED_FIRST) ? !done_r :
    1'b0;

  assign servo_rise = servo_on_s && !servo_q_r;

  // Stroke-end handling while detection moves the motor
  assign both_off = limits_used && !fwd_on && !rev_on;
  assign rev_needed = limits_used && !both_off &&
                      ((dir_r == 1'b0 && !fwd_on) ||
                       (dir_r == 1'b1 && !rev_on));

  // Fault sources during detection, first match names the cause
  assign fault_cause =
    both_off ? pole_pkg::FC_LIMITS :
    (minute && detect_disturb) ? pole_pkg::FC_DISTURB :
    (minute && travel_over) ? pole_pkg::FC_TRAVEL :
    detect_fail ? pole_pkg::FC_ENGINE :
    pole_pkg::FC_NONE;
  assign fault_hit = (state_r == pole_pkg::ST_DETECT) &&
                     (fault_cause != pole_pkg::FC_NONE);
  assign finished = (state_r == pole_pkg::ST_DETECT) && !fault_hit &&
                    servo_on_s && detect_done;

  // Next state of the sequencer
  always_comb begin
    state_nxt = state_r;
    cause_nxt = cause_r;
    unique case (state_r)
      pole_pkg::ST_IDLE: begin
        if (servo_rise) begin
          state_nxt = detect_needed ? pole_pkg::ST_DETECT :
                      pole_pkg::ST_RUN;
        end
      end
      pole_pkg::ST_DETECT: begin
        if (fault_hit) begin
          state_nxt = pole_pkg::ST_FAULT;
          cause_nxt = fault_cause;
        end else if (!servo_on_s) begin
          state_nxt = pole_pkg::ST_IDLE;
        end else if (detect_done) begin
          state_nxt = pole_pkg::ST_RUN;
        end
      end
      pole_pkg::ST_RUN: begin
        if (!servo_on_s) begin
          state_nxt = pole_pkg::ST_IDLE;
        end
      end
      pole_pkg::ST_FAULT: begin
        if (fault_clear) begin
          state_nxt = pole_pkg::ST_IDLE;
          cause_nxt = pole_pkg::FC_NONE;
        end
      end
    endcase
    if (soft_reset) begin
      state_nxt = pole_pkg::ST_IDLE;
      cause_nxt = pole_pkg::FC_NONE;
    end
  end

  // Done flag: set on clean finish, dropped by a software reset
  assign done_nxt = soft_reset ? 1'b0 : (done_r || finished);

  // Direction starts forward and turns at a stroke end
  assign dir_nxt = (state_r != pole_pkg::ST_DETECT) ? 1'b0 :
                   rev_needed ? !dir_r : dir_r;

  // Sequencer flops
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_r <= pole_pkg::ST_IDLE;
      cause_r <= pole_pkg::FC_NONE;
      done_r <= 1'b0;
      dir_r <= 1'b0;
      servo_q_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cause_r <= cause_nxt;
      done_r <= done_nxt;
      dir_r <= dir_nxt;
      servo_q_r <= servo_on_s;
    end
  end

  // Test-run selection is latched only when the drive restarts
  always_ff @(posedge core_clk) begin
    if (reset) begin
      test_active_r <= 1'b0;
    end else if (soft_reset) begin
      test_active_r <= cfg_r[pole_pkg::TEST_BIT];
    end
  end

  // Travel of the current detection run
  assign meter_clear = (state_r != pole_pkg::ST_DETECT);

  travel_meter #(
    .W(TRAVEL_W),
    .LIMIT(TRAVEL_LIMIT)
  ) u_travel_meter (
    .core_clk(core_clk),
    .reset(reset),
    .clear(meter_clear),
    .step(move_step),
    .count(travel_count),
    .over(travel_over)
  );

  // Settings registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cfg_r <= pole_pkg::CFG_RESET;
      irq_mask_r <= '0;
      torque_ofs_r <= '0;
    end else begin
      if (wr_cfg) begin
        cfg_r <= cfg_nxt;
      end
      if (wr_irq_mask) begin
        irq_mask_r <= reg_wdata[pole_pkg::IRQ_W-1:0];
      end
      if (wr_torque) begin
        torque_ofs_r <= reg_wdata[OFFSET_W-1:0];
      end
    end
  end

  // Events; a command before ready counts as rejected
  assign events[pole_pkg::IRQ_DONE] = finished;
  assign events[pole_pkg::IRQ_FAULT] = fault_hit;
  assign events[pole_pkg::IRQ_REVERSE] =
    (state_r == pole_pkg::ST_DETECT) && rev_needed;
  assign events[pole_pkg::IRQ_EARLY] = pos_cmd && !ready;

  // Sticky status, write one to clear, a new event wins
  assign irq_stat_nxt =
    (irq_stat_r & ~(wr_irq_stat ? reg_wdata[pole_pkg::IRQ_W-1:0] : '0))
    | events;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  // Read multiplexer, unmapped offsets read zero
  always_comb begin
    rdata_nxt = '0;
    unique case (reg_addr)
      pole_pkg::OFS_CFG: rdata_nxt = cfg_r;
      pole_pkg::OFS_STATUS: begin
        rdata_nxt[pole_pkg::ST_STATE_LSB +: 2] = state_r;
        rdata_nxt[pole_pkg::ST_DONE_BIT] = done_r;
        rdata_nxt[pole_pkg::ST_READY_BIT] = ready;
        rdata_nxt[pole_pkg::ST_DIR_BIT] = dir_r;
        rdata_nxt[pole_pkg::ST_TEST_BIT] = test_active_r;
        rdata_nxt[pole_pkg::ST_CAUSE_LSB +: 3] = cause_r;
      end
      pole_pkg::OFS_IRQ_STAT: rdata_nxt[pole_pkg::IRQ_W-1:0] = irq_stat_r;
      pole_pkg::OFS_IRQ_MASK: rdata_nxt[pole_pkg::IRQ_W-1:0] = irq_mask_r;
      pole_pkg::OFS_TORQUE_OFS: rdata_nxt[OFFSET_W-1:0] = torque_ofs_r;
      pole_pkg::OFS_TRAVEL: rdata_nxt[TRAVEL_W-1:0] = travel_count;
      default: rdata_nxt = '0;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= reg_rd ? rdata_nxt : '0;
    end
  end

  assign reg_rdata = rdata_r;

  // Engine and controller outputs
  assign detect_run = (state_r == pole_pkg::ST_DETECT);
  assign detect_dir = dir_r;
  assign detect_method_minute = minute;
  assign minute_method_response =
    cfg_r[pole_pkg::RESP_LSB +: pole_pkg::RESP_W];
  assign ready = (state_r == pole_pkg::ST_RUN) && servo_on_s;
  assign torque_offset_eff = detect_run ? '0 : torque_ofs_r;
  assign initial_pole_detect_fault = (state_r == pole_pkg::ST_FAULT);
  assign test_run_active = test_active_r;

endmodule : pole_detection_sequencer

// ===== tb/pole_sva.sv
// Port-level checker for the pole detection sequencer
`timescale 1ns/1ps
module pole_sva #(
  parameter int OFFSET_W = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Register port
  input wire logic [pole_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pole_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  // Controller and engine side
  input wire logic servo_on_pin,
  input wire logic ready,
  input wire logic detect_run,
  input wire logic detect_method_minute,
  input wire logic [pole_pkg::RESP_W-1:0] minute_method_response,
  input wire logic detect_done,
  input wire logic detect_fail,
  input wire logic detect_disturb,
  // Status side
  input wire logic [OFFSET_W-1:0] torque_offset_eff,
  input wire logic initial_pole_detect_fault,
  input wire logic test_run_active
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  // Write data of the previous cycle, for settings checks
  logic [31:0] wd_q;
  always_ff @(posedge core_clk) begin
    wd_q <= reg_wdata;
  end

  // Command writes and start sequences
  wire cmd_wr = reg_wr && reg_addr == pole_pkg::OFS_CMD;
  wire cfg_wr = reg_wr && reg_addr == pole_pkg::OFS_CFG;
  sequence s_servo_up;
    $rose(servo_on_pin) && !initial_pole_detect_fault && !ready && !detect_run;
  endsequence
  sequence s_moving;
    ##[1:5] (detect_run || ready);
  endsequence

  property p_start;
    s_servo_up |-> s_moving;
  endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_torque;
    detect_run |-> torque_offset_eff == '0;
  endproperty
  a_torque: assert property (p_torque) else $error("offset");
  property p_method;
    cfg_wr |=> detect_method_minute == (wd_q[6:4] == 3'h4);
  endproperty
  a_method: assert property (p_method) else $error("method");
  property p_resp;
    cfg_wr |=> minute_method_response == wd_q[19:16];
  endproperty
  a_resp: assert property (p_resp) else $error("response");
  property p_fail;
    detect_run && (detect_fail || detect_disturb && detect_method_minute)
      |=> initial_pole_detect_fault;
  endproperty
  a_fail: assert property (p_fail) else $error("no fault");
  property p_done;
    detect_run && detect_done && !detect_fail && !detect_disturb &&
      !detect_method_minute |=> !detect_run && !initial_pole_detect_fault;
  endproperty
  a_done: assert property (p_done) else $error("done");
  property p_hold;
    initial_pole_detect_fault && !cmd_wr |=> initial_pole_detect_fault;
  endproperty
  a_hold: assert property (p_hold) else $error("fault lost");
  property p_test;
    $changed(test_run_active) |-> $past(cmd_wr) && wd_q[0];
  endproperty
  a_test: assert property (p_test) else $error("test run");
  property p_noready;
    initial_pole_detect_fault |-> !ready && !detect_run;
  endproperty
  a_noready: assert property (p_noready) else $error("ready");
endmodule : pole_sva

// ===== tb/engine_model.sv
// Behavioural detection engine answering the sequencer
`timescale 1ns/1ps
module engine_model #(
  parameter logic [7:0] LAT = 8'h05
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Run request and answer kind (0 done, 1 fail, 2 disturb, 3 runaway)
  input wire logic detect_run,
  input wire logic [1:0] mode,
  // Answers
  output logic detect_done,
  output logic detect_fail,
  output logic detect_disturb,
  output logic move_step
);
  logic [7:0] n_r;
  logic hit;
  // Counts cycles of the current run
  always_ff @(posedge core_clk) begin
    if (reset || !detect_run) n_r <= 8'h00;
    else if (n_r != 8'hFF) n_r <= n_r + 8'h01;
  end
  // One answer after a fixed time; runaway keeps stepping
  assign hit = detect_run && n_r == LAT;
  assign detect_done = hit && mode == 2'h0;
  assign detect_fail = hit && mode == 2'h1;
  assign detect_disturb = hit && mode == 2'h2;
  assign move_step = detect_run && (mode == 2'h3 || n_r < 8'h03);
endmodule : engine_model

// ===== tb/pole_detection_sequencer_tb_top.sv
// Testbench for the pole detection sequencer
`timescale 1ns/1ps
module pole_detection_sequencer_tb_top;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic servo_on_pin = 1'b0;
  logic pos_cmd = 1'b0;
  logic forward_travel_limit = 1'b1;
  logic reverse_travel_limit = 1'b1;
  logic [1:0] mode = 2'h0;
  logic [31:0] reg_rdata;
  logic [15:0] torque_offset_eff;
  logic [3:0] minute_method_response;
  logic ready, detect_run, detect_dir, detect_method_minute, irq;
  logic detect_done, detect_fail, detect_disturb, move_step;
  logic initial_pole_detect_fault, test_run_active;
  int err_count = 0;
  int num_checks = 0;
  localparam logic [31:0] CFG_T [7] = '{32'h201, 32'h205, 32'h200,
    32'h203, 32'h201, 32'h1, 32'h0};
  localparam logic [6:0] SR_T = 7'h7C;
  localparam logic [6:0] EXP_T = 7'h72;

  // Design with a short travel bound of five steps
  pole_detection_sequencer #(.ENC_RES_NM(100000)) dut_u (.core_clk, .reset,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .servo_on_pin,
    .pos_cmd, .ready, .forward_travel_limit, .reverse_travel_limit,
    .detect_run, .detect_dir, .detect_method_minute, .minute_method_response,
    .detect_done, .detect_fail, .detect_disturb, .move_step,
    .torque_offset_eff, .initial_pole_detect_fault, .test_run_active, .irq);
  engine_model eng_u (.core_clk, .reset, .detect_run, .mode, .detect_done,
    .detect_fail, .detect_disturb, .move_step);

  // Clock of 100 ns
  initial forever #50 core_clk = ~core_clk;

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task test_done;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done
  task wt(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : wt
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : rd
  // Servo-on of the single axis; no other axis is on meanwhile
  task servo(input logic v);
    @(posedge core_clk);
    servo_on_pin <= v;
  endtask : servo
  task pulse_cmd;
    @(posedge core_clk);
    pos_cmd <= 1'b1;
    @(posedge core_clk);
    pos_cmd <= 1'b0;
  endtask : pulse_cmd

  // Hang guard
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    test_done();
  end

  // Test sequence
  initial begin
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    rd(8'h00, 32'h0000_0001);
    rd(8'h08, 32'h0000_0000);
    rd(8'hFC, 32'h0000_0000);
    wr(8'h14, 32'h0000_1234);
    wr(8'h10, 32'h0000_0009);
    servo(1'b1);
    wt(4);
    chk(32'(detect_run), 32'h1);
    chk(32'(torque_offset_eff), 32'h0);
    wt(8);
    chk(32'(ready), 32'h1);
    chk(32'(torque_offset_eff), 32'h1234);
    chk(32'(irq), 32'h1);
    rd(8'h08, 32'h0000_000E);
    wr(8'h0C, 32'h0000_0001);
    chk(32'(irq), 32'h0);
    servo(1'b0);
    wt(4);
    pulse_cmd();
    wt(1);
    chk(32'(irq), 32'h1);
    rd(8'h0C, 32'h0000_0008);
    wr(8'h0C, 32'h0000_0008);
    $display("test first run done");
    for (int i = 0; i < 7; i++) begin
      if (SR_T[i]) wr(8'h04, 32'h0000_0001);
      wr(8'h00, CFG_T[i]);
      servo(1'b1);
      wt(4);
      chk(32'(detect_run), 32'(EXP_T[i]));
      wt(8);
      chk(32'(ready), 32'h1);
      servo(1'b0);
      wt(4);
    end
    $display("test schedule done");
    wr(8'h00, 32'h0000_1000);
    chk(32'(test_run_active), 32'h0);
    wr(8'h04, 32'h0000_0001);
    chk(32'(test_run_active), 32'h1);
    rd(8'h08, 32'h0000_0020);
    wr(8'h00, 32'h000F_0040);
    chk(32'(detect_method_minute), 32'h1);
    chk(32'(minute_method_response), 32'hF);
    mode <= 2'h2;
    wr(8'h04, 32'h0000_0001);
    servo(1'b1);
    wt(12);
    chk(32'(initial_pole_detect_fault), 32'h1);
    rd(8'h08, 32'h0000_0203);
    servo(1'b0);
    wt(4);
    chk(32'(initial_pole_detect_fault), 32'h1);
    wr(8'h04, 32'h0000_0002);
    chk(32'(initial_pole_detect_fault), 32'h0);
    mode <= 2'h3;
    servo(1'b1);
    wt(14);
    rd(8'h08, 32'h0000_0303);
    servo(1'b0);
    wr(8'h04, 32'h0000_0002);
    $display("test minute method done");
    wr(8'h00, 32'h0000_0000);
    chk(32'(detect_method_minute), 32'h0);
    servo(1'b1);
    wt(4);
    @(posedge core_clk);
    forward_travel_limit <= 1'b0;
    wt(4);
    chk(32'(detect_dir), 32'h1);
    @(posedge core_clk);
    reverse_travel_limit <= 1'b0;
    wt(4);
    chk(32'(initial_pole_detect_fault), 32'h1);
    servo(1'b0);
    wr(8'h04, 32'h0000_0002);
    wr(8'h00, 32'h0000_0100);
    servo(1'b1);
    wt(10);
    chk(32'(detect_run), 32'h1);
    chk(32'(initial_pole_detect_fault), 32'h0);
    rd(8'h18, 32'h0000_0008);
    servo(1'b0);
    wt(4);
    // Engine failure under the position method ends in the fault state
    mode <= 2'h1;
    servo(1'b1);
    wt(12);
    rd(8'h08, 32'h0000_0403);
    servo(1'b0);
    $display("test stroke ends done");
    test_done();
  end
endmodule : pole_detection_sequencer_tb_top

bind pole_detection_sequencer pole_sva #(.OFFSET_W(OFFSET_W)) sva_u (
  .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .servo_on_pin(servo_on_pin),
  .ready(ready), .detect_run(detect_run),
  .detect_method_minute(detect_method_minute),
  .minute_method_response(minute_method_response),
  .detect_done(detect_done), .detect_fail(detect_fail),
  .detect_disturb(detect_disturb), .torque_offset_eff(torque_offset_eff),
  .initial_pole_detect_fault(initial_pole_detect_fault),
  .test_run_active(test_run_active));
